// ### src/sysop_decoder.v
// Purpose: Decode of system coprocessor instruction words with reserved trap flag
// Assumes: Issue stage presents one word with instr_valid_i; result registered one cycle later
// Notes:   Other primary opcodes give no decode; only the held-back and reserved-with-trap slots trap
// Behaviour
// - Reserved-with-trap encodings raise the reserved-instruction flag, no operation.
// - Undefined-reserved function codes may trap; this design traps them.
// - Held-back primary slots (64-bit mul/div, LL/SC, cop2 ld/st) trap.
// - System opcode: rs picks move-from, move-to, branch or operation class.
// - rd 11000 is debug group, rd 11001 is performance group.
// - Debug function 000,010..111 pick breakpoint registers; 001 reserved.
// - Branch class rt 00000..00011 are four branches; others trap.
// - Operation class functions: xlate read/writes/probe, exception return, int en/dis.
`include "sysop_decode_map.vh"
`timescale 1ns/1ps
`default_nettype none

module sysop_decoder (
	input  wire              ref_clk_i,
	input  wire              rst_i,
	input  wire              instr_valid_i,
	input  wire [31:0]       instr_i,
	output reg               dec_valid_o,
	output reg  [`OP_W-1:0]  dec_op_o,
	output reg               reserved_instr_o,
	output reg               system_coproc_opcode_o
);

	// Held-back primary slots: column 0,2,4,6 of rows 110 and 111
	function held_back_slot;
		input [5:0] opc;
		begin
			held_back_slot = (opc[5:4] == 2'b11) && (opc[0] == 1'b0);
		end
	endfunction

	// Debug group register index for one direction
	function [`OP_W-1:0] debug_op;
		input [2:0] fn;
		input       to_dir;
		begin
			case (fn)
				3'h0: debug_op = to_dir ? `OP_WR_BPC  : `OP_RD_BPC;
				3'h2: debug_op = to_dir ? `OP_WR_IAB  : `OP_RD_IAB;
				3'h3: debug_op = to_dir ? `OP_WR_IABM : `OP_RD_IABM;
				3'h4: debug_op = to_dir ? `OP_WR_DAB  : `OP_RD_DAB;
				3'h5: debug_op = to_dir ? `OP_WR_DABM : `OP_RD_DABM;
				3'h6: debug_op = to_dir ? `OP_WR_DVB  : `OP_RD_DVB;
				3'h7: debug_op = to_dir ? `OP_WR_DVBM : `OP_RD_DVBM;
				default: debug_op = `OP_NONE;
			endcase
		end
	endfunction

	// Classes of the second decode stage
	localparam [2:0] CLS_NONE = 3'h0;
	localparam [2:0] CLS_FROM = 3'h1;
	localparam [2:0] CLS_TO   = 3'h2;
	localparam [2:0] CLS_BR   = 3'h3;
	localparam [2:0] CLS_OPER = 3'h4;

	// Primary slots that trap, beyond the held-back group
	function primary_trap;
		input [5:0] opc_f;
		begin
			case (opc_f)
				`OPC_RSV_A: primary_trap = 1'b1;
				`OPC_RSV_B: primary_trap = 1'b1;
				`OPC_RSV_C: primary_trap = 1'b1;
				`OPC_RSV_D: primary_trap = 1'b1;
				default:    primary_trap = 1'b0;
			endcase
		end
	endfunction

	// Second stage: the whole rs field picks the class
	function [2:0] rs_class;
		input [4:0] rs_f;
		begin
			case (rs_f)
				`RS_MOVE_FROM: rs_class = CLS_FROM;
				`RS_MOVE_TO:   rs_class = CLS_TO;
				`RS_BRANCH:    rs_class = CLS_BR;
				`RS_OPERATION: rs_class = CLS_OPER;
				default:       rs_class = CLS_NONE;
			endcase
		end
	endfunction

	// Performance group: function bit 0 alone picks the register
	function [`OP_W-1:0] perf_op;
		input sel_cnt;
		input to_dir;
		begin
			case ({to_dir, sel_cnt})
				2'b00:   perf_op = `OP_RD_PEV;
				2'b01:   perf_op = `OP_RD_PCNT;
				2'b10:   perf_op = `OP_WR_PEV;
				default: perf_op = `OP_WR_PCNT;
			endcase
		end
	endfunction

	// Branch class: all five rt bits are checked
	function [`OP_W-1:0] branch_op;
		input [4:0] rt_f;
		begin
			case (rt_f)
				`RT_BR_FALSE:   branch_op = `OP_BR_FALSE;
				`RT_BR_TRUE:    branch_op = `OP_BR_TRUE;
				`RT_BR_FALSE_L: branch_op = `OP_BR_FALSE_L;
				`RT_BR_TRUE_L:  branch_op = `OP_BR_TRUE_L;
				default:        branch_op = `OP_NONE;
			endcase
		end
	endfunction

	// Operation class: seven defined codes, the rest give none
	function [`OP_W-1:0] oper_op;
		input [5:0] fn_f;
		begin
			case (fn_f)
				`FN_XLATE_READ:   oper_op = `OP_XLATE_READ;
				`FN_XLATE_WR_IDX: oper_op = `OP_XLATE_WR_IDX;
				`FN_XLATE_WR_RND: oper_op = `OP_XLATE_WR_RND;
				`FN_XLATE_PROBE:  oper_op = `OP_XLATE_PROBE;
				`FN_EXC_RETURN:   oper_op = `OP_EXC_RETURN;
				`FN_INT_ENABLE:   oper_op = `OP_INT_ENABLE;
				`FN_INT_DISABLE:  oper_op = `OP_INT_DISABLE;
				default:          oper_op = `OP_NONE;
			endcase
		end
	endfunction

	wire [5:0] opc = instr_i[`OPC_HI:`OPC_LO];
	wire [4:0] rs  = instr_i[`RS_HI:`RS_LO];
	wire [4:0] rt  = instr_i[`RT_HI:`RT_LO];
	wire [4:0] rd  = instr_i[`RD_HI:`RD_LO];
	wire [5:0] fn  = instr_i[`FN_HI:`FN_LO];

	// First stage: primary opcode
	wire             rsv_prim   = held_back_slot(opc) | primary_trap(opc);
	// Second stage: rs class
	wire [2:0]       cls        = rs_class(rs);
	wire             is_move    = (cls == CLS_FROM) || (cls == CLS_TO);
	wire             to_dir     = (cls == CLS_TO);
	// Third stage: register group of the moves
	wire             grp_debug  = (rd == `RD_DEBUG_GRP);
	wire             grp_perf   = (rd == `RD_PERF_GRP);
	// Other rd values are ordinary moves beyond this block
	wire             plain_move = is_move && !grp_debug && !grp_perf;
	wire [`OP_W-1:0] op_debug   = debug_op(fn[2:0], to_dir);
	wire [`OP_W-1:0] op_perf    = perf_op(fn[0], to_dir);

	reg [`OP_W-1:0] op_nxt;
	reg             rsv_nxt;
	reg             is_sys_nxt;

	always @* begin
		op_nxt     = `OP_NONE;
		rsv_nxt    = 1'b0;
		is_sys_nxt = (opc == `OPC_SYSCOP);
		if (rsv_prim) begin
			rsv_nxt = 1'b1;
		end else if (is_sys_nxt) begin
			case (cls)
				CLS_FROM, CLS_TO: begin
					if (grp_debug)
						op_nxt = op_debug;
					else if (grp_perf)
						op_nxt = op_perf;
				end
				CLS_BR: begin
					op_nxt = branch_op(rt);
				end
				CLS_OPER: begin
					op_nxt = oper_op(fn);
				end
				default: begin
					op_nxt = `OP_NONE;
				end
			endcase
			// Trapping undefined codes too keeps later stages free of unknown behaviour
			if (op_nxt == `OP_NONE && !plain_move)
				rsv_nxt = 1'b1;
		end
	end

	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dec_valid_o            <= 1'b0;
			dec_op_o               <= `OP_NONE;
			reserved_instr_o       <= 1'b0;
			system_coproc_opcode_o <= 1'b0;
		end else begin
			dec_valid_o            <= instr_valid_i;
			// Op and flag never both set
			dec_op_o               <= instr_valid_i ? op_nxt : `OP_NONE;
			reserved_instr_o       <= instr_valid_i & rsv_nxt;
			system_coproc_opcode_o <= instr_valid_i & is_sys_nxt;
		end
	end

endmodule // sysop_decoder
`default_nettype wire

// ### src/sysop_decode_map.vh
// Purpose: Field positions and encodings for the system coprocessor opcode decoder
// Assumes: 32-bit instruction words
// Notes:   Definitions only
`ifndef SYSOP_DECODE_MAP_VH
`define SYSOP_DECODE_MAP_VH

`define OPC_HI          31
`define OPC_LO          26
`define RS_HI           25
`define RS_LO           21
`define RT_HI           20
`define RT_LO           16
`define RD_HI           15
`define RD_LO           11
`define FN_HI           5
`define FN_LO           0

// Primary slots reserved with a guaranteed trap
`define OPC_RSV_A       6'h12
`define OPC_RSV_B       6'h13
`define OPC_RSV_C       6'h1d
`define OPC_RSV_D       6'h3b

`define OPC_SYSCOP      6'h10
`define RS_MOVE_FROM    5'h00
`define RS_MOVE_TO      5'h04
`define RS_BRANCH       5'h08
`define RS_OPERATION    5'h10
`define RD_DEBUG_GRP    5'h18
`define RD_PERF_GRP     5'h19

`define RT_BR_FALSE     5'h00
`define RT_BR_TRUE      5'h01
`define RT_BR_FALSE_L   5'h02
`define RT_BR_TRUE_L    5'h03

`define FN_XLATE_READ   6'h01
`define FN_XLATE_WR_IDX 6'h02
`define FN_XLATE_WR_RND 6'h06
`define FN_XLATE_PROBE  6'h08
`define FN_EXC_RETURN   6'h18
`define FN_INT_ENABLE   6'h38
`define FN_INT_DISABLE  6'h39

// Decoded operation codes
`define OP_W            5
`define OP_NONE         5'h00
`define OP_RD_BPC       5'h01
`define OP_RD_IAB       5'h02
`define OP_RD_IABM      5'h03
`define OP_RD_DAB       5'h04
`define OP_RD_DABM      5'h05
`define OP_RD_DVB       5'h06
`define OP_RD_DVBM      5'h07
`define OP_WR_BPC       5'h08
`define OP_WR_IAB       5'h09
`define OP_WR_IABM      5'h0a
`define OP_WR_DAB       5'h0b
`define OP_WR_DABM      5'h0c
`define OP_WR_DVB       5'h0d
`define OP_WR_DVBM      5'h0e
`define OP_RD_PEV       5'h0f
`define OP_RD_PCNT      5'h10
`define OP_WR_PEV       5'h11
`define OP_WR_PCNT      5'h12
`define OP_BR_FALSE     5'h13
`define OP_BR_TRUE      5'h14
`define OP_BR_FALSE_L   5'h15
`define OP_BR_TRUE_L    5'h16
`define OP_XLATE_READ   5'h17
`define OP_XLATE_WR_IDX 5'h18
`define OP_XLATE_WR_RND 5'h19
`define OP_XLATE_PROBE  5'h1a
`define OP_EXC_RETURN   5'h1b
`define OP_INT_ENABLE   5'h1c
`define OP_INT_DISABLE  5'h1d

`endif

// ### sim/sysop_decoder_asserts.sv
// Purpose: Port checks of the decoder
// Assumes: One clock, async reset
// Notes:   Bound at the foot
`include "sysop_decode_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sysop_decoder_asserts (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic        dec_valid_o,
	input wire logic [4:0]  dec_op_o,
	input wire logic        reserved_instr_o,
	input wire logic        system_coproc_opcode_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire logic sc = instr_valid_i && instr_i[31:26] == `OPC_SYSCOP;
	wire logic br = sc && instr_i[25:21] == `RS_BRANCH;
	idle_quiet_a: assert property (!instr_valid_i |=> !dec_valid_o && !reserved_instr_o) else $error("idle");
	word_answer_a: assert property (instr_valid_i |=> dec_valid_o) else $error("no answer");
	one_class_a: assert property (reserved_instr_o |-> dec_op_o == 5'h00) else $error("both");
	held_slot_a: assert property (instr_valid_i && instr_i[31:30] == 2'h3 && !instr_i[26]
		|=> reserved_instr_o && !system_coproc_opcode_o) else $error("held");
	sys_flag_a: assert property (instr_valid_i
		|=> system_coproc_opcode_o == ($past(instr_i[31:26]) == `OPC_SYSCOP)) else $error("sys");
	rs_resv_a: assert property (sc && !(instr_i[25:21] inside {5'h00, 5'h04, 5'h08, 5'h10})
		|=> reserved_instr_o) else $error("rs");
	br_op_a: assert property (br && instr_i[20:16] < 5'h04
		|=> dec_op_o == `OP_BR_FALSE + $past(instr_i[17:16])) else $error("branch");
	br_resv_a: assert property (br && instr_i[20:16] > 5'h03 |=> reserved_instr_o) else $error("rt");
	prim_trap_a: assert property (instr_valid_i && (instr_i[31:26] == `OPC_RSV_A || instr_i[31:26] == `OPC_RSV_B
		|| instr_i[31:26] == `OPC_RSV_C || instr_i[31:26] == `OPC_RSV_D)
		|=> reserved_instr_o && dec_op_o == 5'h00) else $error("primary");
endmodule // sysop_decoder_asserts
bind sysop_decoder sysop_decoder_asserts u_sysop_decoder_asserts (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .dec_valid_o(dec_valid_o), .dec_op_o(dec_op_o),
	.reserved_instr_o(reserved_instr_o), .system_coproc_opcode_o(system_coproc_opcode_o));
`default_nettype wire

// ### sim/issue_model.sv
// Purpose: Issue stage feeding words
// Assumes: One word per call
// Notes:   Word inverted once released
`timescale 1ns/1ps
`default_nettype none
module issue_model (
	input  wire logic        ref_clk_i,
	output var  logic        valid_o,
	output var  logic [31:0] word_o
);
	initial begin
		valid_o = 1'b0;
		word_o = 32'h0;
	end
	task automatic send(input logic [31:0] w);
		@(posedge ref_clk_i);
		valid_o <= 1'b1;
		word_o <= w;
		@(posedge ref_clk_i);
		valid_o <= 1'b0;
		word_o <= ~w; // Stale word must not look valid
	endtask
endmodule // issue_model
`default_nettype wire

// ### sim/system_coproc_opcode_decoder_bench.sv
// Purpose: Self-checking decoder bench
// Assumes: Answer one cycle after a word
// Notes:   Undefined-reserved function codes not judged; rs 00001 and rt 00100 expect a trap
`include "sysop_decode_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s %h %h", n, e, s); end end
module system_coproc_opcode_decoder_bench;
	logic        ref_clk_i;
	logic        rst_i;
	logic        v;
	logic [31:0] w;
	logic        dv;
	logic [4:0]  op;
	logic        rsv;
	logic        sy;
	int          n_fail;
	int          comparisons;
	int          cyc;
	issue_model u_issue_model (.ref_clk_i(ref_clk_i), .valid_o(v), .word_o(w));
	sysop_decoder u_sysop_decoder (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(v), .instr_i(w),
		.dec_valid_o(dv), .dec_op_o(op), .reserved_instr_o(rsv), .system_coproc_opcode_o(sy));
	task automatic run(input logic [31:0] x, input logic [4:0] e, input logic r);
		u_issue_model.send(x);
		#1;
		`CHK("valid", 1'b1, dv)
		`CHK("op", e, op)
		`CHK("resv", r, rsv)
	endtask
	task automatic op_class;
		logic [5:0] fn [7] = '{6'h01, 6'h02, 6'h06, 6'h08, 6'h18, 6'h38, 6'h39};
		for (int i = 0; i < 7; i++) begin
			run({11'h210, 15'h0, fn[i]}, `OP_XLATE_READ + 5'(i), 1'b0);
			`CHK("sys", 1'b1, sy)
		end
	endtask
	task automatic other_words;
		logic [5:0] trap_opc [4] = '{`OPC_RSV_A, `OPC_RSV_B, `OPC_RSV_C, `OPC_RSV_D};
		for (int i = 0; i < 4; i++)
			run({trap_opc[i], 26'h0}, 5'h00, 1'b1);
		run(32'h8c000000, 5'h00, 1'b0);
		`CHK("sys", 1'b0, sy)
		run({11'h204, 10'h00c, 11'h0}, 5'h00, 1'b0);
		`CHK("sys", 1'b1, sy)
		@(posedge ref_clk_i);
		#1;
		`CHK("idle", 1'b0, dv)
		`CHK("idle op", 5'h00, op)
	endtask
	task automatic branch_class;
		for (int i = 0; i < 5; i++)
			run({11'h208, 5'(i), 16'h0}, i < 4 ? `OP_BR_FALSE + 5'(i) : 5'h00, i > 3);
	endtask
	task automatic reg_moves;
		for (int i = 0; i < 8; i++)
			if (i != 1) begin
				run({11'h200, 10'h018, 8'h0, 3'(i)}, `OP_RD_BPC + 5'(i ? i - 1 : 0), 1'b0);
				run({11'h204, 10'h018, 8'h0, 3'(i)}, `OP_WR_BPC + 5'(i ? i - 1 : 0), 1'b0);
			end
		for (int i = 0; i < 2; i++) begin
			run({11'h200, 10'h019, 10'h0, 1'(i)}, `OP_RD_PEV + 5'(i), 1'b0);
			run({11'h204, 10'h019, 10'h0, 1'(i)}, `OP_WR_PEV + 5'(i), 1'b0);
		end
	endtask
	task automatic reserved_slots;
		for (int i = 0; i < 8; i++) begin
			run({2'h3, 3'(i), 1'b0, 26'h0}, 5'h00, 1'b1);
			`CHK("sys", 1'b0, sy)
		end
		run(32'h40200000, 5'h00, 1'b1);
	endtask
	task automatic close_out;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc > 1000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		rst_i = 1'b1;
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		op_class();
		branch_class();
		reg_moves();
		reserved_slots();
		other_words();
		close_out();
	end
endmodule // system_coproc_opcode_decoder_bench
`default_nettype wire
